/* File: src/ref_monitor_pkg.sv */
// Constants, types and register map of the reference clock monitor.
// Assumes one 20 MHz system clock and an APB register bus.
package ref_monitor_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam int         IDX_W          = 10;
  localparam int         ADDR_W         = 12;
  localparam logic [9:0] HOLD_MASK_IDX  = 10'h034;
  localparam logic [9:0] PHASE_MEM_IDX  = 10'h047;
  localparam logic [9:0] TOL_IDX        = 10'h04B;
  localparam logic [9:0] NOMINAL_IDX    = 10'h060;
  localparam logic [9:0] FAIL_IDX       = 10'h061;
  localparam logic [9:0] STATUS_IDX     = 10'h062;
  localparam logic [9:0] IRQ_MASK_IDX   = 10'h063;

  // ==========================================================
  // Values after reset
  localparam logic [7:0]  PHASE_MEM_RESET = 8'h0A;
  localparam logic [7:0]  TOL_RESET       = 8'h55;
  localparam logic [3:0]  HOLD_MASK_RESET = 4'h7;
  localparam logic [3:0]  HOLD_MASK_RSVD  = 4'h8;
  localparam logic [31:0] NOMINAL_RESET   = 32'h0000_0000;
  localparam logic [3:0]  IRQ_MASK_RESET  = 4'h0;

  // ==========================================================
  // Field positions
  localparam int CFM_LSB  = 0;
  localparam int SCM_LSB  = 4;
  localparam int FAIL_LOS = 0;
  localparam int FAIL_SCM = 1;
  localparam int FAIL_CFM = 2;
  localparam int FAIL_GST = 3;

  // ==========================================================
  // Phase memory encoding: code = round(32 * log(limit * 1e5))
  localparam int         PHASE_MEM_SCALE = 32;
  localparam logic [7:0] PHASE_MEM_10US  = 8'h00;
  localparam logic [7:0] PHASE_MEM_100US = 8'h20;
  localparam logic [7:0] PHASE_MEM_1MS   = 8'h40;
  localparam logic [7:0] PHASE_MEM_930MS = 8'h9F;

  // ==========================================================
  // Timing: periods are kept in 1.25 ns ticks, 40 added per 20 MHz clk cycle
  localparam int          SAMPLE_MHZ     = 800;
  localparam int          CLK_MHZ        = 20;
  localparam int          TICK_PS        = 1_000_000 / SAMPLE_MHZ;
  localparam logic [31:0] TICKS_PER_CLK  = 32'(SAMPLE_MHZ / CLK_MHZ);
  localparam int          CFM_WIN_LOG2   = 3;
  localparam logic [2:0]  CFM_WIN_LAST   = 3'h7;
  localparam logic [41:0] TOL_DEN        = 42'd1000;

  // ==========================================================
  // Types
  typedef struct packed {
    logic        valid;
    logic [31:0] ticks;
  } meas_t;

  typedef struct packed {
    logic [35:0] lo;
    logic [35:0] hi;
  } limits_t;

  typedef struct packed {
    logic              sel;
    logic              enable;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } apb_req_t;

  // Tolerance in tenths of a percent:
  // 0.1, 0.5, 1, 2, 5, 10, 20, 50 percent
  function automatic logic [9:0] tol_num(input logic [2:0] code);
    logic [9:0] n;
    n = 10'd1;
    unique case (code)
      3'h0: n = 10'd1;
      3'h1: n = 10'd5;
      3'h2: n = 10'd10;
      3'h3: n = 10'd20;
      3'h4: n = 10'd50;
      3'h5: n = 10'd100;
      3'h6: n = 10'd200;
      3'h7: n = 10'd500;
    endcase
    return n;
  endfunction

endpackage

/* File: src/ref_period_counter.sv */
// Reference period counter: synchronises the reference and counts
// 1.25 ns ticks between its rising edges.
// Assumes the reference is asynchronous to clk.
`timescale 1ns/100ps
module ref_period_counter (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic                  ref_clk_in,
  output ref_monitor_pkg::meas_t     meas,
  output logic [31:0]                running
);
  import ref_monitor_pkg::*;

  logic       sync1;
  logic       sync2;
  logic       sync3;
  logic       ref_level;
  logic       seen_edge;
  logic       rise;

  // ==========================================================
  // Three-stage synchroniser; a level counts once stages 2 and 3 agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else if (ce) begin
      sync1 <= ref_clk_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign rise = sync2 & sync3 & ~ref_level;

  // Filtered level of the reference
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_level <= 1'b0;
    end else if (ce && sync2 == sync3) begin
      ref_level <= sync3;
    end
  end

  // ==========================================================
  // Tick counter; saturates so a dead reference never wraps to "good"
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      running   <= 32'h0000_0000;
      seen_edge <= 1'b0;
      meas      <= '0;
    end else if (ce) begin
      meas.valid <= rise & seen_edge;                     // RULE8
      if (rise) begin
        meas.ticks <= running;
        running    <= TICKS_PER_CLK;
        seen_edge  <= 1'b1;
      end else if (running <= 32'hFFFF_FFFF - TICKS_PER_CLK) begin
        running <= running + TICKS_PER_CLK;               // RULE8
      end
    end
  end

endmodule

/* File: src/ref_clock_monitor_limits.sv */
// Reference clock monitor limits: phase memory bound, coarse frequency
// and single-cycle tolerance checks, holdover mask and interrupt.
// Assumes an APB master on clk and an asynchronous reference input.
//
// Summary of operation
// [RULE1] Phase memory code is round(32*log(limit*1e5)), written by software.
// [RULE2] Software should choose a limit of at least half a reference period.
// [RULE3] Typical codes: 0x00 10us, 0x20 100us, 0x40 1ms, 0x9F 930ms.
// [RULE4] Bits 2:0 pick the coarse frequency tolerance, 0.1 to 50 percent.
// [RULE5] Coarse frequency violation raises a readable failure indicator.
// [RULE6] Bits 6:4 pick the single-cycle tolerance, 0.1 to 50 percent.
// [RULE7] A reference cycle outside tolerance raises the single-cycle flag.
// [RULE8] Periods are measured in 1.25 ns ticks of an 800 MHz sampler; the code samples on clk and adds 40 ticks per cycle.
// [RULE9] Software keeps single-cycle tolerance within reference-rate bounds.
// [RULE10] A failure triggers holdover only while its holdover mask bit is high.
// [RULE11] Ticks per period are compared with nominal plus and minus tolerance.
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
module ref_clock_monitor_limits (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          ce,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [ref_monitor_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                   pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          ref_clk_in,
  input  wire logic                          los_fail,
  input  wire logic                          gst_fail,
  output logic [7:0]                         phase_memory_limit,
  output logic                               scm_fail,
  output logic                               cfm_fail,
  output logic                               holdover_request,
  output logic                               irq
);
  import ref_monitor_pkg::*;

  apb_req_t          req;
  logic [IDX_W-1:0]  idx;
  logic              wr_done;
  logic              setup;
  logic              mapped;
  logic [31:0]       rd_mux;

  logic [7:0]        phase_memory_bound;
  logic [7:0]        frequency_monitor_tolerances;
  logic [3:0]        holdover_mask;
  logic [31:0]       nominal_period;
  logic [3:0]        fail_status;
  logic [3:0]        irq_mask;

  meas_t             meas;
  logic [31:0]       running;
  logic [41:0]       scm_tol_full;
  logic [41:0]       cfm_tol_full;
  limits_t           scm_lim;
  limits_t           cfm_lim;
  logic [35:0]       cfm_sum;
  logic [2:0]        cfm_count;
  logic [35:0]       next_cfm_sum;
  logic [3:0]        fail_now;
  logic [3:0]        fail_prev;
  logic [3:0]        fail_rise;

  // ==========================================================
  // Period measurement
  ref_period_counter u_counter (
    .clk        (clk),
    .rst        (rst),
    .ce         (ce),
    .ref_clk_in (ref_clk_in),
    .meas       (meas),
    .running    (running)
  );

  // ==========================================================
  // APB decode
  assign req     = '{sel: psel, enable: penable, write: pwrite,
                     addr: paddr, wdata: pwdata};
  assign idx     = req.addr[ADDR_W-1:2];
  assign setup   = req.sel & ~req.enable & ~pready;
  assign wr_done = req.sel & req.enable & pready & req.write & mapped;

  // Registered map lookup keeps every bus output straight from a flop
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (idx)
      PHASE_MEM_IDX: rd_mux = {24'h00_0000, phase_memory_bound};
      TOL_IDX:       rd_mux = {24'h00_0000,
                               frequency_monitor_tolerances};
      HOLD_MASK_IDX: rd_mux = {24'h00_0000, HOLD_MASK_RSVD,
                               holdover_mask};
      NOMINAL_IDX:   rd_mux = nominal_period;
      FAIL_IDX:      rd_mux = {28'h000_0000, fail_now};  // RULE5
      STATUS_IDX:    rd_mux = {28'h000_0000, fail_status};
      IRQ_MASK_IDX:  rd_mux = {28'h000_0000, irq_mask};
      default:       mapped = 1'b0;
    endcase
  end

  // Zero-wait answer: pready rises in the first access cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= req.write ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // ==========================================================
  // Software-written registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_memory_bound <= PHASE_MEM_RESET;
    end else if (ce && wr_done && idx == PHASE_MEM_IDX) begin
      phase_memory_bound <= req.wdata[7:0];              // RULE1
    end
  end

  // Reserved bits 3 and 7 keep their default
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frequency_monitor_tolerances <= TOL_RESET;
    end else if (ce && wr_done && idx == TOL_IDX) begin
      frequency_monitor_tolerances[CFM_LSB +: 3] <=
        req.wdata[CFM_LSB +: 3];                         // RULE4
      frequency_monitor_tolerances[SCM_LSB +: 3] <=
        req.wdata[SCM_LSB +: 3];                         // RULE6
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      holdover_mask <= HOLD_MASK_RESET;
    end else if (ce && wr_done && idx == HOLD_MASK_IDX) begin
      holdover_mask <= req.wdata[3:0];
    end
  end

  // Zero nominal period turns both checks off
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nominal_period <= NOMINAL_RESET;
    end else if (ce && wr_done && idx == NOMINAL_IDX) begin
      nominal_period <= req.wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_mask <= IRQ_MASK_RESET;
    end else if (ce && wr_done && idx == IRQ_MASK_IDX) begin
      irq_mask <= req.wdata[3:0];
    end
  end

  // Phase memory code is only stored; the loop interprets it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_memory_limit <= PHASE_MEM_RESET;
    end else if (ce) begin
      phase_memory_limit <= phase_memory_bound;          // RULE3
    end
  end

  // ==========================================================
  // Tolerance windows; registered to keep the divider off the
  // compare path. A tolerance change takes two cycles to apply.
  assign scm_tol_full = ({10'h000, nominal_period} *
    {32'h0000_0000, tol_num(frequency_monitor_tolerances[SCM_LSB +: 3])})
    / TOL_DEN;
  assign cfm_tol_full = ({10'h000, nominal_period} *
    {32'h0000_0000, tol_num(frequency_monitor_tolerances[CFM_LSB +: 3])})
    / TOL_DEN;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scm_lim <= '0;
      cfm_lim <= '0;
    end else if (ce) begin
      scm_lim.lo <= {4'h0, nominal_period} - scm_tol_full[35:0]; // RULE11
      scm_lim.hi <= {4'h0, nominal_period} + scm_tol_full[35:0]; // RULE11
      cfm_lim.lo <= ({4'h0, nominal_period} - cfm_tol_full[35:0])
                    << CFM_WIN_LOG2;
      cfm_lim.hi <= ({4'h0, nominal_period} + cfm_tol_full[35:0])
                    << CFM_WIN_LOG2;
    end
  end

  // ==========================================================
  // Single-cycle check: each period, and a missing edge once the
  // running count already passes the upper bound
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scm_fail <= 1'b0;
    end else if (ce) begin
      if (nominal_period == 32'h0000_0000) begin
        scm_fail <= 1'b0;
      end else if ({4'h0, running} > scm_lim.hi) begin
        scm_fail <= 1'b1;                                // RULE7
      end else if (meas.valid) begin
        scm_fail <= ({4'h0, meas.ticks} < scm_lim.lo) ||
                    ({4'h0, meas.ticks} > scm_lim.hi);   // RULE7
      end
    end
  end

  // ==========================================================
  // Coarse frequency check: averages a window of eight periods,
  // so it tolerates single-cycle jitter the other check catches
  assign next_cfm_sum = cfm_sum + {4'h0, meas.ticks};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfm_sum   <= 36'h0_0000_0000;
      cfm_count <= 3'h0;
      cfm_fail  <= 1'b0;
    end else if (ce) begin
      if (nominal_period == 32'h0000_0000) begin
        cfm_fail  <= 1'b0;
        cfm_sum   <= 36'h0_0000_0000;
        cfm_count <= 3'h0;
      end else if ({4'h0, running} > cfm_lim.hi) begin
        cfm_fail <= 1'b1;                                // RULE5
      end else if (meas.valid) begin
        cfm_count <= cfm_count + 3'h1;
        if (cfm_count == CFM_WIN_LAST) begin
          cfm_sum  <= 36'h0_0000_0000;
          cfm_fail <= (next_cfm_sum < cfm_lim.lo) ||
                      (next_cfm_sum > cfm_lim.hi);       // RULE5
        end else begin
          cfm_sum <= next_cfm_sum;
        end
      end
    end
  end

  // ==========================================================
  // Failure indicators and holdover trigger
  always_comb begin
    fail_now           = 4'h0;
    fail_now[FAIL_LOS] = los_fail;
    fail_now[FAIL_SCM] = scm_fail;
    fail_now[FAIL_CFM] = cfm_fail;
    fail_now[FAIL_GST] = gst_fail;
  end

  // A low mask bit keeps that failure from forcing holdover
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      holdover_request <= 1'b0;
    end else if (ce) begin
      holdover_request <= |(fail_now & holdover_mask);   // RULE10
    end
  end

  // ==========================================================
  // Sticky event status, write one to clear; a new rise wins
  assign fail_rise = fail_now & ~fail_prev;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fail_prev   <= 4'h0;
      fail_status <= 4'h0;
    end else if (ce) begin
      fail_prev <= fail_now;
      if (wr_done && idx == STATUS_IDX) begin
        fail_status <= (fail_status & ~req.wdata[3:0]) | fail_rise;
      end else begin
        fail_status <= fail_status | fail_rise;
      end
    end
  end

  // Level interrupt while any unmasked status bit stands
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(fail_status & irq_mask);
    end
  end

endmodule

/* File: verification/ref_limits_monitor.sv */
// Checker of the APB answer, register read-back and holdover cause.
// Assumes a bind to the block's top module and a single clock domain.
`timescale 1ns/100ps
module ref_limits_monitor
  import ref_monitor_pkg::*;
(
  input wire logic                                clk,
  input wire logic                                rst,
  input wire logic                                ce,
  input wire logic                                psel,
  input wire logic                                penable,
  input wire logic                                pwrite,
  input wire logic [ref_monitor_pkg::ADDR_W-1:0]  paddr,
  input wire logic [31:0]                         pwdata,
  input wire logic [31:0]                         prdata,
  input wire logic                                pready,
  input wire logic                                pslverr,
  input wire logic                                los_fail,
  input wire logic                                gst_fail,
  input wire logic [7:0]                          phase_memory_limit,
  input wire logic                                scm_fail,
  input wire logic                                cfm_fail,
  input wire logic                                holdover_request
);
  // ==========================================================
  // Decode of the word index seen on the bus
  logic [IDX_W-1:0] idx;
  logic             mapped;
  assign idx    = paddr[ADDR_W-1:2];
  assign mapped = idx inside {HOLD_MASK_IDX, PHASE_MEM_IDX, TOL_IDX,
                  NOMINAL_IDX, FAIL_IDX, STATUS_IDX, IRQ_MASK_IDX};

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Bus phases; ce low freezes the answer, so it gates every step
  sequence setup_s;
    psel && !penable && !pready && ce;
  endsequence
  sequence done_s;
    psel && penable && pready && ce;
  endsequence

  pready_answer_a: assert property (setup_s |=> pready)
    else $error("no answer after setup");
  pready_pulse_a: assert property (pready && ce |=> !pready)
    else $error("ready held too long");
  idle_quiet_a: assert property (!psel && ce |=> !pready)
    else $error("ready without select");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  addr_err_a: assert property (setup_s |=> pslverr == !$past(mapped))
    else $error("error flag wrong for address");
  write_zero_a: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("write returned data");
  phase_copy_a: assert property (
    done_s ##0 (pwrite && idx == PHASE_MEM_IDX)
    |=> ##1 phase_memory_limit == $past(pwdata[7:0], 2))
    else $error("phase limit output not updated");
  phase_read_a: assert property (
    setup_s ##0 (!pwrite && idx == PHASE_MEM_IDX)
    |=> prdata == {24'h0, phase_memory_limit})
    else $error("phase limit read differs");
  tol_rsvd_a: assert property (
    setup_s ##0 (!pwrite && idx == TOL_IDX)
    |=> prdata[31:8] == 24'h0 && !prdata[7] && !prdata[3])
    else $error("tolerance reserved bits set");
  mask_rsvd_a: assert property (
    setup_s ##0 (!pwrite && idx == HOLD_MASK_IDX)
    |=> prdata[7:4] == 4'h8)
    else $error("mask upper nibble wrong");
  hold_cause_a: assert property (
    (!los_fail && !gst_fail && !scm_fail && !cfm_fail && ce) [*2]
    |=> !holdover_request)
    else $error("holdover without failure");
endmodule

/* File: verification/ref_source.sv */
// Reference clock source feeding the monitor's reference input.
// Assumes run and half_ns change just after a system clock edge.
`timescale 1ns/100ps
module ref_source (
  input  wire logic        run,
  input  wire logic [15:0] half_ns,
  output logic             ref_clk
);
  // ==========================================================
  // Square wave; a 13 ns lag keeps edges off the system clock edges.
  // Stopped, it rests low, which looks like a missing edge.
  initial ref_clk = 1'b0;
  always begin
    if (run === 1'b1) begin
      #(half_ns);
      ref_clk = ~ref_clk;
    end else begin
      ref_clk = 1'b0;
      @(posedge run);
      #13;
    end
  end
endmodule

/* File: verification/test_ref_clock_monitor_limits.sv */
// Self-checking bench of the reference monitor limits block.
// Assumes the design package and the reference source model.
`timescale 1ns/100ps
module test_ref_clock_monitor_limits;
  import ref_monitor_pkg::*;
  typedef struct packed {
    logic [9:0]  idx;
    logic        wr;
    logic [31:0] wdata;
    logic [31:0] exp;
  } row_t;
  logic              clk, rst, ce, psel, penable, pwrite, run, e, err;
  logic              los_fail, gst_fail, ref_clk_in, pready, pslverr;
  logic              scm_fail, cfm_fail, holdover_request, irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [7:0]        phase_memory_limit;
  logic [15:0]       half_ns;
  int                fails, n_tests;
  row_t              rows [12];
  int                tenths [8] = '{1, 5, 10, 20, 50, 100, 200, 500};

  ref_clock_monitor_limits dut (.clk(clk), .rst(rst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_clk_in(ref_clk_in), .los_fail(los_fail),
    .gst_fail(gst_fail), .phase_memory_limit(phase_memory_limit),
    .scm_fail(scm_fail), .cfm_fail(cfm_fail),
    .holdover_request(holdover_request), .irq(irq));
  ref_source u_src (.run(run), .half_ns(half_ns), .ref_clk(ref_clk_in));

  // ==========================================================
  // 20 MHz system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the leading edge keeps back-to-back calls from
  // driving psel twice in the same time step
  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      fails++;
      print_verdict();
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    los_fail = 1'b0;
    gst_fail = 1'b0;
    run = 1'b0;
    half_ns = 16'h0AF0;
    fails = 0;
    n_tests = 0;
    rows[0]  = '{HOLD_MASK_IDX, 1'b0, 32'h0, 32'h87};
    rows[1]  = '{PHASE_MEM_IDX, 1'b0, 32'h0, 32'h0A};
    rows[2]  = '{TOL_IDX, 1'b0, 32'h0, 32'h55};
    rows[3]  = '{NOMINAL_IDX, 1'b0, 32'h0, 32'h0};
    rows[4]  = '{IRQ_MASK_IDX, 1'b0, 32'h0, 32'h0};
    rows[5]  = '{STATUS_IDX, 1'b0, 32'h0, 32'h0};
    rows[6]  = '{PHASE_MEM_IDX, 1'b1, 32'h00, 32'h00};
    rows[7]  = '{PHASE_MEM_IDX, 1'b1, 32'h20, 32'h20};
    rows[8]  = '{PHASE_MEM_IDX, 1'b1, 32'h40, 32'h40};
    rows[9]  = '{PHASE_MEM_IDX, 1'b1, 32'h9F, 32'h9F};
    rows[10] = '{TOL_IDX, 1'b1, 32'hFF, 32'h77};
    rows[11] = '{FAIL_IDX, 1'b1, 32'hF, 32'h0};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    check(32'(phase_memory_limit), 32'h0A);
    for (int i = 0; i < 12; i++) begin
      if (rows[i].wr) apb(1'b1, rows[i].idx, rows[i].wdata);
      apb(1'b0, rows[i].idx, 32'h0);
      check(rd, rows[i].exp);
      if (rows[i].idx == PHASE_MEM_IDX) begin
        check(32'(phase_memory_limit), rows[i].exp);
      end
    end
    // Unmapped words answer with an error and no data
    apb(1'b0, 10'h3FF, 32'h0);
    check(32'(err), 32'h1);
    check(rd, 32'h0);
    apb(1'b1, 10'h3FE, 32'hFFFF_FFFF);
    check(32'(err), 32'h1);
    // Every code on both checks; period runs 4480 ticks, 480 over nominal
    apb(1'b1, NOMINAL_IDX, 32'h0000_0FA0);
    apb(1'b1, HOLD_MASK_IDX, 32'h2);
    apb(1'b1, IRQ_MASK_IDX, 32'h2);
    run <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      // Opposite codes on the two checks catch a swapped field
      apb(1'b1, TOL_IDX, {25'h0, c[2:0], 1'b0, 3'(7 - c)});
      repeat (2100) @(posedge clk);
      e = (4000 * tenths[c] / 1000) < 480;
      check(32'(scm_fail), 32'(e));
      check(32'(holdover_request), 32'(e));
      e = (4000 * tenths[7 - c] / 1000) < 480;
      check(32'(cfm_fail), 32'(e));
    end
    // Sticky status, mask and clear of the interrupt
    check(32'(irq), 32'h1);
    apb(1'b0, STATUS_IDX, 32'h0);
    check(rd, 32'h6);
    apb(1'b1, IRQ_MASK_IDX, 32'h0);
    repeat (3) @(posedge clk);
    check(32'(irq), 32'h0);
    apb(1'b1, IRQ_MASK_IDX, 32'h2);
    apb(1'b1, STATUS_IDX, 32'h6);
    repeat (3) @(posedge clk);
    check(32'(irq), 32'h0);
    // Exact nominal period passes the tightest code, then edges stop
    apb(1'b1, TOL_IDX, 32'h0);
    run <= 1'b0;
    repeat (100) @(posedge clk);
    half_ns <= 16'h09C4;
    run <= 1'b1;
    repeat (2100) @(posedge clk);
    check(32'(scm_fail), 32'h0);
    check(32'(cfm_fail), 32'h0);
    run <= 1'b0;
    repeat (200) @(posedge clk);
    check(32'(scm_fail), 32'h1);
    apb(1'b1, NOMINAL_IDX, 32'h0);
    repeat (3) @(posedge clk);
    check(32'(scm_fail), 32'h0);
    // Holdover follows the unsynchronised failure inputs per mask bit
    apb(1'b1, HOLD_MASK_IDX, 32'h9);
    los_fail <= 1'b1;
    repeat (3) @(posedge clk);
    check(32'(holdover_request), 32'h1);
    apb(1'b1, HOLD_MASK_IDX, 32'h8);
    repeat (3) @(posedge clk);
    check(32'(holdover_request), 32'h0);
    gst_fail <= 1'b1;
    repeat (3) @(posedge clk);
    check(32'(holdover_request), 32'h1);
    // Clock enable low freezes the holdover output
    ce <= 1'b0;
    gst_fail <= 1'b0;
    repeat (3) @(posedge clk);
    check(32'(holdover_request), 32'h1);
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    check(32'(holdover_request), 32'h0);
    // Reset in mid-run restores the limits
    rst <= 1'b1;
    los_fail <= 1'b0;
    gst_fail <= 1'b0;
    repeat (12) @(posedge clk);
    check(32'(phase_memory_limit), 32'h0A);
    rst <= 1'b0;
    apb(1'b0, TOL_IDX, 32'h0);
    check(rd, 32'h55);
    print_verdict();
  end
endmodule

bind ref_clock_monitor_limits ref_limits_monitor u_mon (.clk(clk),
  .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .los_fail(los_fail), .gst_fail(gst_fail),
  .phase_memory_limit(phase_memory_limit), .scm_fail(scm_fail),
  .cfm_fail(cfm_fail), .holdover_request(holdover_request));
